// [src/ata_gpio_pkg.sv]
/*
 * package for the ata-attached gpio ports: register addresses, select
 * field layout, reset values and the bus request carrier.
 * assumes a single 200 mhz clock domain and byte-wide register access.
 */
package ata_gpio_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int PORT_COUNT = 5;           // ports a to e
    localparam int PORT_WIDTH = 8;           // lines per port

    // ------------------------------------------------------------------
    // register addresses in the command block
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_OUTPUT_VALUE = 3'h4;
    localparam logic [2:0] ADDR_PIN_DIRECTION = 3'h5;
    localparam logic [2:0] ADDR_PORT_SELECT = 3'h6;

    // ------------------------------------------------------------------
    // select register fields
    // ------------------------------------------------------------------
    localparam int SEL_PORT_LSB = 0;         // port code bits 3..0
    localparam int SEL_PORT_MSB = 3;
    localparam int SEL_DEVICE_BIT = 4;       // master/slave select
    localparam logic [3:0] PORT_CODE_FIRST = 4'h1;
    localparam logic [3:0] PORT_CODE_LAST = 4'h5;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_SELECT = 8'h00;
    localparam logic [7:0] RESET_DIRECTION = 8'h00;
    localparam logic [7:0] RESET_OUTPUT = 8'h00;

    // ------------------------------------------------------------------
    // bus request carrier: one byte access per cycle
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;            // one-cycle write strobe
        logic rd;            // one-cycle read strobe
        logic [2:0] addr;    // command block register address
        logic [7:0] wdata;   // write byte
    } bus_req_t;

endpackage

// [src/gpio_port_bank.sv]
/*
 * one 8-line port: output value and direction registers, pin drive.
 * assumes writes arrive already decoded for this port.
 */
`timescale 1ns/1ps

module gpio_port_bank #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic wr_value,
    input wire logic wr_dir,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] out_value;          // latched output levels
    logic [WIDTH-1:0] dir;                // 1 = drive, 0 = input
    logic [WIDTH-1:0] next_out_value;
    logic [WIDTH-1:0] next_dir;

    // next values for both registers
    always_comb begin
        next_out_value = out_value;
        next_dir = dir;
        if (wr_value) begin
            next_out_value = wdata;
        end
        if (wr_dir) begin
            next_dir = wdata;
        end
    end

    // register, reset to all inputs
    always_ff @(posedge clock) begin
        if (!nrst) begin
            out_value <= ata_gpio_pkg::RESET_OUTPUT;
            dir <= ata_gpio_pkg::RESET_DIRECTION;
        end else if (clk_en) begin
            out_value <= next_out_value;
            dir <= next_dir;
        end
    end

    // per-line drive: enable from direction, level from output value
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_line
            assign pin_oe[b] = dir[b];
            assign pin_out[b] = out_value[b];
        end
    endgenerate

endmodule // gpio_port_bank

// [src/ata_gpio_ports.sv]
/*
 * ata-attached gpio adapter: five 8-line bidirectional ports behind the
 * command block registers 4, 5 and 6 of a parallel ata channel.
 * assumes host strobes are synchronous to clock, one cycle each, and
 * that pin inputs are already synchronous to clock.
 */
`timescale 1ns/1ps

module ata_gpio_ports #(
    parameter int PORTS = ata_gpio_pkg::PORT_COUNT,
    parameter int WIDTH = ata_gpio_pkg::PORT_WIDTH
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic is_slave,
    input wire ata_gpio_pkg::bus_req_t req,
    output logic [7:0] rdata,
    output logic rdata_valid,
    input wire logic [PORTS*WIDTH-1:0] pin_in,
    output logic [PORTS*WIDTH-1:0] pin_out,
    output logic [PORTS*WIDTH-1:0] pin_oe
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    initial begin
        if (PORTS < 1 || PORTS > 15) begin
            $error("ports must be 1 to 15");
        end
        if (WIDTH != 8) begin
            $error("port width must be 8");    // byte-wide transfers only
        end
    end

    // ------------------------------------------------------------------
    // select register and decode
    // ------------------------------------------------------------------
    logic [4:0] sel;                 // device bit + port code, bits 7-5 dropped
    logic [4:0] next_sel;
    logic dev_match;                 // select bit equals strap
    logic port_ok;                   // port code in range
    logic [3:0] code;
    logic [PORTS*WIDTH-1:0] bank_out;
    logic [PORTS*WIDTH-1:0] bank_oe;

    assign code = sel[ata_gpio_pkg::SEL_PORT_MSB:ata_gpio_pkg::SEL_PORT_LSB];
    assign dev_match = (sel[ata_gpio_pkg::SEL_DEVICE_BIT] == is_slave);
    assign port_ok = (code >= ata_gpio_pkg::PORT_CODE_FIRST)
                   && (code <= 4'(PORTS));

    // select write: store low five bits, hold otherwise
    always_comb begin
        next_sel = sel;
        if (req.wr && req.addr == ata_gpio_pkg::ADDR_PORT_SELECT) begin
            next_sel = req.wdata[4:0];
        end
    end

    // select register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sel <= ata_gpio_pkg::RESET_SELECT[4:0];
        end else if (clk_en) begin
            sel <= next_sel;
        end
    end

    // ------------------------------------------------------------------
    // per-port banks
    // ------------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            logic hit;                   // this port selected and addressed
            assign hit = clk_en && dev_match && port_ok
                       && (code == 4'(p + 1));
            gpio_port_bank #(.WIDTH(WIDTH)) u_bank (
                .clock(clock),
                .nrst(nrst),
                .clk_en(clk_en),
                .wr_value(hit && req.wr
                          && req.addr == ata_gpio_pkg::ADDR_OUTPUT_VALUE),
                .wr_dir(hit && req.wr
                        && req.addr == ata_gpio_pkg::ADDR_PIN_DIRECTION),
                .wdata(req.wdata),
                .pin_out(bank_out[p*WIDTH +: WIDTH]),
                .pin_oe(bank_oe[p*WIDTH +: WIDTH])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path and registered pin outputs
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;
    logic next_rdata_valid;
    logic [3:0] idx;                 // zero-based port index

    assign idx = code - ata_gpio_pkg::PORT_CODE_FIRST;

    // reads of value/direction return live pins; select reads as zero
    always_comb begin
        next_rdata = 8'h00;
        next_rdata_valid = 1'b0;
        if (req.rd && dev_match) begin
            next_rdata_valid = 1'b1;
            if (port_ok && (req.addr == ata_gpio_pkg::ADDR_OUTPUT_VALUE
                || req.addr == ata_gpio_pkg::ADDR_PIN_DIRECTION)) begin
                next_rdata = pin_in[idx*WIDTH +: WIDTH];
            end
        end
    end

    // output flops
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
            pin_out <= '0;
            pin_oe <= '0;
        end else if (clk_en) begin
            rdata <= next_rdata;
            rdata_valid <= next_rdata_valid;
            pin_out <= bank_out;
            pin_oe <= bank_oe;
        end
    end

endmodule // ata_gpio_ports

// [dv/ata_gpio_ports_chk.sv]
/* checker for the gpio adapter top ports.
   assumes binding to the top module, one clock domain. */
`timescale 1ns/1ps

module ata_gpio_ports_chk #(
    parameter int PORTS = 5,
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic is_slave,
    input wire ata_gpio_pkg::bus_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic [PORTS*WIDTH-1:0] pin_in,
    input wire logic [PORTS*WIDTH-1:0] pin_out,
    input wire logic [PORTS*WIDTH-1:0] pin_oe
);
    logic [7:0] sel; // shadow of the select register
    logic [7:0] next_sel;
    wire logic ok = sel[4] == is_slave; // strap match
    wire logic hit = ok && sel[3:0] >= 4'h1 && sel[3:0] <= 4'h5;
    wire logic rd_p = clk_en && req.rd && req.addr[2:1] == 2'b10 && hit;
    wire logic wr_d = clk_en && req.wr && req.addr == 3'h5 && hit;
    wire logic wr_v = clk_en && req.wr && req.addr == 3'h4 && hit;
    function automatic logic [7:0] pick(input logic [PORTS*WIDTH-1:0] x, input logic [3:0] c);
        return x[WIDTH*(c-4'h1) +: 8];
    endfunction
    // shadow follows every select write
    always_comb begin
        next_sel = !nrst ? 8'h00 : (clk_en && req.wr && req.addr == 3'h6) ? req.wdata : sel;
    end
    always_ff @(posedge clock) begin
        sel <= next_sel;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    rd_valid_a: assert property (clk_en && req.rd && ok |=> rdata_valid)
        else $error("read not answered");
    rd_refuse_a: assert property (clk_en && !(req.rd && ok) |=> !rdata_valid)
        else $error("stray read answer");
    rd_pins_a: assert property (rd_p |=> rdata == pick($past(pin_in), $past(sel[3:0])))
        else $error("read data not pin levels");
    sel_hidden_a: assert property (clk_en && req.rd && req.addr == 3'h6 |=> rdata == 8'h00)
        else $error("select readable");
    dir_write_a: assert property (wr_d |=> ##1 pick(pin_oe, $past(sel[3:0], 2)) == $past(req.wdata, 2))
        else $error("direction not applied");
    val_write_a: assert property (wr_v |=> ##1 pick(pin_out, $past(sel[3:0], 2)) == $past(req.wdata, 2))
        else $error("value not applied");
    oe_cause_a: assert property ($changed(pin_oe) |-> $past(wr_d, 2) || $past(!nrst) || $past(!nrst, 2))
        else $error("direction changed without write");
    out_cause_a: assert property ($changed(pin_out) |-> $past(wr_v, 2) || $past(!nrst) || $past(!nrst, 2))
        else $error("value changed without write");
    reset_a: assert property (disable iff (1'b0) !nrst && clk_en |=> pin_oe == '0 && !rdata_valid)
        else $error("reset not applied");
endmodule // ata_gpio_ports_chk

// [dv/ata_host_model.sv]
/* host side model: single-byte register accesses on the strobe bus.
   assumes read answers land on the taking edge and are sampled 1 ns after it. */
`timescale 1ns/1ps

module ata_host_model (
    input wire logic clock,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    output ata_gpio_pkg::bus_req_t req
);
    initial req = '0; // idle bus
    // sole agent, one byte per access, one-cycle strobe
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
        @(posedge clock);
        #1 req = '{w, !w, a, d};
        @(posedge clock);
        #1 req = '0;
        q = rdata;
        v = rdata_valid;
    endtask
endmodule // ata_host_model

// [dv/ata_gpio_ports_tb.sv]
/* testbench for the gpio adapter: host model on the bus,
   undriven lines take their levels from ext. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module ata_gpio_ports_tb;
    typedef struct packed {
        logic [3:0] code;
        logic [7:0] dir;
        logic [7:0] val;
        logic [7:0] ext;
    } row_t;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic is_slave = 1'b1;
    logic [39:0] ext = 40'h00_0000_0000; // far-side levels
    logic [39:0] pin_in;
    logic [39:0] pin_out;
    logic [39:0] pin_oe;
    logic [7:0] rdata;
    logic rdata_valid;
    logic [7:0] q;
    logic v;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    ata_gpio_pkg::bus_req_t req;
    row_t rows[5] = '{'{4'h1, 8'hFF, 8'h3C, 8'h00}, '{4'h2, 8'h00, 8'hFF, 8'h96},
        '{4'h3, 8'hA5, 8'h0F, 8'hC3}, '{4'h4, 8'h0F, 8'h5A, 8'hE1}, '{4'h5, 8'h81, 8'h7E, 8'h18}};
    logic [7:0] bad[3] = '{8'h10, 8'h16, 8'h01};
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext); // driven lines read back
    ata_gpio_ports ata_gpio_ports_i (.clock, .nrst, .clk_en, .is_slave, .req, .rdata,
        .rdata_valid, .pin_in, .pin_out, .pin_oe);
    ata_host_model ata_host_model_i (.clock, .rdata, .rdata_valid, .req);
    function automatic logic [7:0] pins(row_t r);
        return (r.dir & r.val) | (~r.dir & r.ext);
    endfunction
    task automatic h(input logic w, input logic [2:0] a, input logic [7:0] d);
        ata_host_model_i.acc(w, a, d, q, v);
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        forever #2.5 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        #1 nrst = 1'b1;
        `CHK(pin_oe, 40'h0)
        foreach (rows[i]) begin
            ext[8*i +: 8] = rows[i].ext;
            h(1'b1, 3'h6, {4'h1, rows[i].code});
            h(1'b1, 3'h5, rows[i].dir);
            h(1'b1, 3'h4, rows[i].val);
            h(1'b0, 3'h4, 8'h00);
            `CHK(q, pins(rows[i]))
            `CHK(pin_oe[8*i +: 8], rows[i].dir)
            `CHK(pin_out[8*i +: 8] & rows[i].dir, rows[i].val & rows[i].dir)
        end
        `CHK(pin_oe, 40'h81_0FA5_00FF)
        // refused codes and strap mismatch move nothing
        foreach (bad[i]) begin
            h(1'b1, 3'h6, bad[i]);
            h(1'b1, 3'h5, 8'h3C);
            h(1'b0, 3'h5, 8'h00);
            `CHK({v, q}, {bad[i][4], 8'h00})
        end
        `CHK(pin_oe, 40'h81_0FA5_00FF)
        h(1'b1, 3'h6, 8'hF3); // port c, upper bits set
        h(1'b0, 3'h6, 8'h00);
        `CHK({v, q}, 9'h100)
        h(1'b0, 3'h5, 8'h00);
        `CHK(q, pins(rows[2]))
        is_slave = 1'b0;
        h(1'b1, 3'h6, 8'h02);
        h(1'b1, 3'h5, 8'h5A);
        h(1'b0, 3'h4, 8'h00);
        `CHK(pin_oe[15:8], 8'h5A)
        // clock enable low: a direction write must be frozen out
        clk_en = 1'b0;
        h(1'b1, 3'h5, 8'hFF);
        repeat (2) @(posedge clock);
        #1 clk_en = 1'b1;
        repeat (2) @(posedge clock);
        #1 `CHK(pin_oe[15:8], 8'h5A)
        nrst = 1'b0;
        repeat (2) @(posedge clock);
        #1 `CHK({pin_oe, pin_out}, 80'h0)
        give_verdict();
    end
endmodule // ata_gpio_ports_tb

bind ata_gpio_ports ata_gpio_ports_chk #(.PORTS(PORTS), .WIDTH(WIDTH)) ata_gpio_ports_chk_i (
    .clock, .nrst, .clk_en, .is_slave, .req, .rdata, .rdata_valid, .pin_in, .pin_out, .pin_oe);
